// [shared/mlink_if.sv]
// Pin bundle between the programming controller and the sensor device
`timescale 1ns/100ps
`default_nettype none
interface mlink_if;
  logic supply_lvl;   // Supply pin: 1 = signalling high, 0 = signalling low
  logic hv_strobe;    // High-voltage programming strobe on the output pin
  logic out_dev;      // Device drive level on the output pin
  logic out_dev_oe;   // Device drives the output pin
  logic out_lvl;      // Resolved digital level of the output pin

  // Output pin idles high while the device is not replying
  assign out_lvl = out_dev_oe ? out_dev : 1'b1;

  modport dev (input supply_lvl, input hv_strobe, output out_dev, output out_dev_oe);
  modport ctl (output supply_lvl, output hv_strobe, input out_lvl);
endinterface
`default_nettype wire

// [shared/mlink_pkg.sv]
// Constants, timing counts and CRC helpers shared by both link ends
package mlink_pkg;
  localparam int CLK_HZ    = 50_000_000;
  localparam int DATA_W    = 30;
  localparam int ADDR_W    = 6;
  localparam int CMD_W     = 2 + ADDR_W + DATA_W;
  localparam int REG_IDX_W = 4;
  localparam int NV_ADDR_BIT = 5;
  localparam int TX_W      = 43;
  localparam int FIFO_DEPTH = 16;
  // Command type codes
  localparam logic [1:0] CMD_ACCESS = 2'h1;
  localparam logic [1:0] CMD_WRITE  = 2'h2;
  localparam logic [1:0] CMD_READ   = 2'h3;
  localparam logic [5:0] ACCESS_ADDR = 6'h24;
  // Frame bit counts, sync bits excluded except in the ACK and TX counts
  localparam logic [5:0] WR_BITS      = 6'h29;
  localparam logic [5:0] RD_BITS      = 6'h0b;
  localparam logic [5:0] ACK_BITS     = 6'h23;
  localparam logic [5:0] SYNC_BITS    = 6'h02;
  localparam logic [5:0] DATA_BITS    = 6'h1e;
  localparam logic [5:0] RD_BODY_BITS = 6'h08;
  localparam logic [5:0] WR_BODY_BITS = 6'h26;
  localparam logic [5:0] TX_WR_BITS   = 6'h2b;
  localparam logic [5:0] TX_RD_BITS   = 6'h0d;
  localparam logic [2:0] CRC_PRESET   = 3'h7;
  // Device timing
  localparam int UNLOCK_TIMEOUT_MS = 8;
  localparam int UNLOCK_TIMEOUT_CYC = UNLOCK_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int READ_REPLY_US = 50;
  localparam logic [12:0] READ_REPLY_CYC = 13'(READ_REPLY_US * (CLK_HZ / 1_000_000));
  localparam int RATE_MIN_BPS = 32000;
  localparam int RATE_MAX_BPS = 80000;
  localparam int BIT_ERR_PCT  = 11;
  localparam logic [12:0] BIT_MIN_CYC =
    13'((CLK_HZ / RATE_MAX_BPS) * (100 - BIT_ERR_PCT) / 100);
  localparam logic [12:0] BIT_MAX_CYC =
    13'((CLK_HZ / RATE_MIN_BPS) * (100 + BIT_ERR_PCT) / 100 + 1);
  // Controller timing
  localparam int CTL_RATE_BPS = 50000;
  localparam logic [15:0] CTL_BIT_CYC  = 16'(CLK_HZ / CTL_RATE_BPS);
  localparam logic [15:0] CTL_HALF_CYC = CTL_BIT_CYC >> 1;
  localparam logic [15:0] CTL_EDGE_CYC = (CTL_BIT_CYC >> 1) + (CTL_BIT_CYC >> 2);
  localparam logic [15:0] CTL_END_CYC  = CTL_BIT_CYC + (CTL_BIT_CYC >> 1);
  localparam logic [15:0] CTL_GAP_CYC  = CTL_BIT_CYC << 1;
  localparam int STROBE_SETUP_US = 40;
  localparam logic [15:0] STROBE_SETUP_CYC = 16'(STROBE_SETUP_US * (CLK_HZ / 1_000_000));
  localparam int STROBE_US = 500;
  localparam int STROBE_CYC = STROBE_US * (CLK_HZ / 1_000_000);
  localparam int READ_WAIT_US = 200;
  localparam int READ_WAIT_CYC = READ_WAIT_US * (CLK_HZ / 1_000_000);

  // One CRC step, g(x) = x^3 + x + 1, message bit in MSB first
  function automatic logic [2:0] crc_next(input logic [2:0] c, input logic b);
    logic fb;
    fb = c[2] ^ b;
    return {c[1], c[0] ^ fb, fb};
  endfunction

  // CRC over the n low bits of v, highest of them first
  function automatic logic [2:0] crc_calc(input logic [40:0] v, input logic [5:0] n);
    logic [2:0] c;
    c = CRC_PRESET;
    for (int i = 40; i >= 0; i--) begin
      if (i < int'(n)) begin
        c = crc_next(c, v[i]);
      end
    end
    return c;
  endfunction
endpackage

// [tb/mlink_sva.sv]
// Pin checks on the link between controller and device ends
`timescale 1ns/100ps
`default_nettype none
module mlink_sva #(
  parameter int STROBE_LEN = 300
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic supply_lvl,
  input wire logic hv_strobe,
  input wire logic out_dev,
  input wire logic out_dev_oe
);
  logic [15:0] sup_cnt_r;  // Cycles since supply last moved
  logic [15:0] out_cnt_r;  // Cycles since device level last moved
  logic [15:0] oe_cnt_r;   // Cycles of device drive
  logic [15:0] stb_cnt_r;  // Cycles of strobe high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // The two since-moved counters saturate so that long idle gaps never wrap
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sup_cnt_r <= 16'hffff;
      out_cnt_r <= 16'hffff;
      oe_cnt_r  <= 16'h0;
      stb_cnt_r <= 16'h0;
    end else begin
      sup_cnt_r <= $changed(supply_lvl) ? 16'h0 : sup_cnt_r + 16'(sup_cnt_r != 16'hffff);
      out_cnt_r <= $changed(out_dev) ? 16'h0 : out_cnt_r + 16'(out_cnt_r != 16'hffff);
      oe_cnt_r  <= out_dev_oe ? oe_cnt_r + 16'h1 : 16'h0;
      stb_cnt_r <= hv_strobe ? stb_cnt_r + 16'h1 : 16'h0;
    end
  end
  a_reply_quiet: assert property (out_dev_oe |-> supply_lvl && !hv_strobe)
    else $error("supply moved during reply");
  a_strobe_quiet: assert property (hv_strobe |-> supply_lvl && !out_dev_oe)
    else $error("strobe overlaps traffic");
  a_reply_sync: assert property ($rose(out_dev_oe) |-> !out_dev ##1 !out_dev)
    else $error("reply does not open with zero sync");
  a_reply_length: assert property ($fell(out_dev_oe) |->
    oe_cnt_r >= 16'd34900 && oe_cnt_r <= 16'd35100)
    else $error("reply length wrong");
  a_reply_delay: assert property ($rose(out_dev_oe) |->
    sup_cnt_r >= 16'd3400 && sup_cnt_r <= 16'd4100)
    else $error("reply start delay wrong");
  a_reply_halfbit: assert property ($changed(out_dev) && $past(out_dev_oe) && out_dev_oe |->
    out_cnt_r >= 16'd490)
    else $error("reply half bit too short");
  a_cmd_halfbit: assert property ($changed(supply_lvl) |-> sup_cnt_r >= 16'd499)
    else $error("command half bit too short");
  a_strobe_len: assert property ($fell(hv_strobe) |-> stb_cnt_r == 16'(STROBE_LEN))
    else $error("strobe length wrong");
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench joining controller and device ends
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mlink_pkg::*;
  localparam logic [29:0] CODE = 30'h0a5c_3a5c;  // Arbitrary access code
  logic clk_i = 1'b0, resetn_i = 1'b0, cmd_valid_i = 1'b0, perm_lock_i = 1'b0;
  logic [CMD_W-1:0]  cmd_i = '0;
  logic [3:0]        cfg_addr_i = 4'h0, idx;
  logic [29:0]       cfg_data_o, rd_data_o, d;
  logic cmd_ready_o, rd_valid_o, rd_err_o, busy_o, unlocked_o, expired_o, sense_pause_o, nv_boost_o;
  logic boost_seen = 1'b0, pause_seen = 1'b0, rdv_seen = 1'b0, rde_seen = 1'b0;
  logic [31:0] seed = 32'h36;
  int fail_count = 0, n_tests = 0, acc = 0;
  mlink_if mlink_if_inst ();
  mlink_dev #(.UNLOCK_CYC(60000), .ACCESS_CODE(CODE)) mlink_dev_inst (.clk_i, .resetn_i,
    .link(mlink_if_inst), .perm_lock_i, .cfg_addr_i, .cfg_data_o, .unlocked_o, .expired_o,
    .sense_pause_o, .nv_boost_o);
  mlink_ctl #(.STROBE_LEN(300), .REPLY_WAIT(6000)) mlink_ctl_inst (.clk_i, .resetn_i,
    .link(mlink_if_inst), .cmd_valid_i, .cmd_ready_o, .cmd_i, .rd_valid_o, .rd_err_o,
    .rd_data_o, .busy_o);
  mlink_sva #(.STROBE_LEN(300)) mlink_sva_inst (.clk_i, .resetn_i,
    .supply_lvl(mlink_if_inst.supply_lvl), .hv_strobe(mlink_if_inst.hv_strobe),
    .out_dev(mlink_if_inst.out_dev), .out_dev_oe(mlink_if_inst.out_dev_oe));
  always #10 clk_i = ~clk_i;
  // Sticky flags for one-cycle pulses and the pause level seen during a transaction
  always @(posedge clk_i) begin
    if (nv_boost_o === 1'b1) boost_seen <= 1'b1;
    if (sense_pause_o === 1'b1) pause_seen <= 1'b1;
    if (rd_valid_o === 1'b1) rdv_seen <= 1'b1;
    if (rd_err_o === 1'b1) rde_seen <= 1'b1;
  end
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Command word to push, built from its fields
  function automatic logic [CMD_W-1:0] mk(input logic [1:0] t, input logic [5:0] a,
                                           input logic [29:0] v);
    return {t, a, v};
  endfunction
  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // Push one command, then wait for the controller to go idle again
  task automatic run(input logic [CMD_W-1:0] c);
    cmd_valid_i <= 1'b1;
    cmd_i       <= c;
    do @(negedge clk_i); while (cmd_ready_o !== 1'b1);
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 120000 && busy_o !== 1'b0; i++) @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic end_sim();
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i    <= 1'b1;
    @(posedge clk_i);
    // Fill the command buffer until it refuses; one entry leaves at once
    cmd_valid_i <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      cmd_i <= mk(CMD_READ, 6'(xorshift()), 30'(xorshift()));
      @(negedge clk_i);
      if (cmd_ready_o !== 1'b1) break;
      acc++;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    check(30'(acc), 30'd17);
    cmd_valid_i <= 1'b0;
    resetn_i    <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i    <= 1'b1;
    @(posedge clk_i);
    run(mk(CMD_ACCESS, ACCESS_ADDR, CODE));
    check(30'(unlocked_o), 30'h1);
    check(30'(pause_seen), 30'h0);
    idx = 4'(xorshift());
    d   = 30'(xorshift());
    run(mk(CMD_WRITE, {2'b10, idx}, d));
    check(30'(boost_seen), 30'h1);
    cfg_addr_i <= idx;
    repeat (2) @(posedge clk_i);
    check(cfg_data_o, d);
    run(mk(CMD_READ, {2'b10, idx}, 30'h0));
    check(rd_data_o, d);
    check(30'({rdv_seen, rde_seen}), 30'h2);
    check(30'(pause_seen), 30'h1);
    check(30'(expired_o), 30'h0);
    end_sim();
  end
  // Watchdog sized well past the three transactions
  initial begin
    repeat (220000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
endmodule
`default_nettype wire

// [verilog/mlink_ctl.sv]
// Programming controller end with its command FIFO
`timescale 1ns/100ps
`default_nettype none
module cmd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;   // Extra bit tells full from empty
    logic [AW:0]             rp;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic        full;
  logic        empty;

  assign full        = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign empty       = (s_r.wp == s_r.rp);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = s_r.mem[s_r.rp[AW-1:0]];

  // Push and pop may share a cycle
  always_comb begin
    s_nxt = s_r;
    if (in_valid_i && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = in_data_i;
      s_nxt.wp = s_r.wp + (AW+1)'(1);
    end
    if (out_ready_i && !empty) begin
      s_nxt.rp = s_r.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

module mlink_ctl
  import mlink_pkg::*;
#(
  parameter int STROBE_LEN = STROBE_CYC,
  parameter int REPLY_WAIT = READ_WAIT_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  mlink_if.ctl                   link,
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire logic [CMD_W-1:0]  cmd_i,
  output logic                   rd_valid_o,
  output logic                   rd_err_o,
  output logic      [DATA_W-1:0] rd_data_o,
  output logic                   busy_o
);
  typedef enum logic [7:0] {
    C_IDLE   = 8'h01,
    C_TX     = 8'h02,
    C_SETUP  = 8'h04,
    C_STROBE = 8'h08,
    C_SGAP   = 8'h10,
    C_RXWAIT = 8'h20,
    C_RX     = 8'h40,
    C_GAP    = 8'h80
  } ctl_st_t;

  typedef struct packed {
    ctl_st_t          st;
    logic [15:0]      cnt;
    logic [TX_W-1:0]  txsh;       // Frame bits, sync first
    logic [5:0]       txn;
    logic [5:0]       total;
    logic [1:0]       kind;
    logic             nv;         // Write targets non-volatile area
    logic             sup;        // Supply pin level
    logic             hv;         // Strobe level
    logic             strobe_one;
    logic             line_q;
    logic [5:0]       rxn;
    logic [32:0]      rxsh;
    logic [2:0]       crc;
    logic             rdv;
    logic             rde;
    logic [DATA_W-1:0] rdata;
  } ctl_state_t;

  ctl_state_t       s_r;
  ctl_state_t       s_nxt;
  logic             f_valid;
  logic             f_ready;
  logic [CMD_W-1:0] f_data;
  logic             fall;
  logic             rise;

  // Stalls while a transaction runs, so the FIFO really fills
  assign f_ready = (s_r.st == C_IDLE);
  assign fall    = ~link.out_lvl & s_r.line_q;
  assign rise    = link.out_lvl & ~s_r.line_q;

  cmd_fifo #(
    .W     (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (cmd_ready_o),
    .in_data_i   (cmd_i),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  (f_data)
  );

  // Transaction sequencer
  always_comb begin
    s_nxt        = s_r;
    s_nxt.line_q = link.out_lvl;
    s_nxt.rdv    = 1'b0;
    s_nxt.rde    = 1'b0;
    s_nxt.cnt    = s_r.cnt + 16'h1;
    s_nxt.sup    = 1'b1;
    unique case (s_r.st)
      C_IDLE: begin
        s_nxt.cnt = 16'h0;
        if (f_valid) begin
          s_nxt.st   = C_TX;
          s_nxt.txn  = 6'h0;
          s_nxt.kind = f_data[CMD_W-1 -: 2];
          s_nxt.nv   = f_data[DATA_W+NV_ADDR_BIT];
          // Reads carry no data field
          if (f_data[CMD_W-1 -: 2] == CMD_READ) begin
            s_nxt.txsh  = {2'h0, f_data[CMD_W-1:DATA_W],
                           crc_calc({33'h0, f_data[CMD_W-1:DATA_W]}, RD_BODY_BITS), 30'h0};
            s_nxt.total = TX_RD_BITS;
          end else begin
            s_nxt.txsh  = {2'h0, f_data, crc_calc({3'h0, f_data}, WR_BODY_BITS)};
            s_nxt.total = TX_WR_BITS;
          end
        end
      end
      // Manchester on the supply pin, idle high between frames
      C_TX: begin
        s_nxt.sup = (s_r.cnt < CTL_HALF_CYC) ? s_r.txsh[TX_W-1] : ~s_r.txsh[TX_W-1];
        if (s_r.cnt == CTL_BIT_CYC - 16'h1) begin
          s_nxt.cnt  = 16'h0;
          s_nxt.txsh = {s_r.txsh[TX_W-2:0], 1'b0};
          s_nxt.txn  = s_r.txn + 6'h1;
          if (s_r.txn == s_r.total - 6'h1) begin
            if (s_r.kind == CMD_READ) begin
              s_nxt.st = C_RXWAIT;
            end else if (s_r.kind == CMD_WRITE && s_r.nv) begin
              s_nxt.st = C_SETUP;
            end else begin
              s_nxt.st = C_GAP;
            end
          end
        end
      end
      // Setup time before the first strobe
      C_SETUP: begin
        if (s_r.cnt == STROBE_SETUP_CYC - 16'h1) begin
          s_nxt.st  = C_STROBE;
          s_nxt.cnt = 16'h0;
          s_nxt.hv  = 1'b1;
        end
      end
      C_STROBE: begin
        if (s_r.cnt == 16'(STROBE_LEN - 1)) begin
          s_nxt.st  = C_SGAP;
          s_nxt.cnt = 16'h0;
          s_nxt.hv  = 1'b0;
        end
      end
      // Second strobe follows one strobe length later
      C_SGAP: begin
        if (s_r.cnt == 16'(STROBE_LEN - 1)) begin
          s_nxt.cnt = 16'h0;
          if (s_r.strobe_one) begin
            s_nxt.st         = C_GAP;
            s_nxt.strobe_one = 1'b0;
          end else begin
            s_nxt.st         = C_STROBE;
            s_nxt.strobe_one = 1'b1;
            s_nxt.hv         = 1'b1;
          end
        end
      end
      // Reply starts with a falling edge; give up after the wait
      C_RXWAIT: begin
        if (fall) begin
          s_nxt.st  = C_RX;
          s_nxt.cnt = CTL_HALF_CYC;
          s_nxt.rxn = 6'h0;
          s_nxt.crc = CRC_PRESET;
        end else if (s_r.cnt == 16'(REPLY_WAIT - 1)) begin
          s_nxt.st  = C_GAP;
          s_nxt.cnt = 16'h0;
          s_nxt.rde = 1'b1;
        end
      end
      // Decode with the own bit period; sync bits skip the CRC
      C_RX: begin
        if ((rise || fall) && s_r.cnt >= CTL_EDGE_CYC) begin
          s_nxt.cnt = 16'h0;
          if (s_r.rxn != 6'h3f) begin
            s_nxt.rxn = s_r.rxn + 6'h1;
          end
          if (s_r.rxn >= SYNC_BITS) begin
            s_nxt.rxsh = {s_r.rxsh[31:0], fall};
            s_nxt.crc  = crc_next(s_r.crc, fall);
          end
        end else if (s_r.cnt > CTL_END_CYC) begin
          s_nxt.st  = C_GAP;
          s_nxt.cnt = 16'h0;
          if (s_r.rxn == ACK_BITS && s_r.crc == 3'h0) begin
            s_nxt.rdv   = 1'b1;
            s_nxt.rdata = s_r.rxsh[32:3];
          end else begin
            s_nxt.rde = 1'b1;
          end
        end
      end
      // RULE8 spacing before next frame
      C_GAP: begin
        if (s_r.cnt == CTL_GAP_CYC - 16'h1) begin
          s_nxt.st = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r        <= '0;
      s_r.st     <= C_IDLE;
      s_r.sup    <= 1'b1;
      s_r.line_q <= 1'b1;
      s_r.crc    <= CRC_PRESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.supply_lvl = s_r.sup;
  assign link.hv_strobe  = s_r.hv;
  assign rd_valid_o      = s_r.rdv;
  assign rd_err_o        = s_r.rde;
  assign rd_data_o       = s_r.rdata;
  assign busy_o          = (s_r.st != C_IDLE);
endmodule
`default_nettype wire

// [verilog/mlink_dev.sv]
// Sensor device end of the Manchester programming link
// Link rules, for this block and for the controller
// RULE1 - Mid-bit edge: rising zero, falling one
// RULE2 - Address and data go MSB first
// RULE3 - Controller starts; device never speaks unasked
// RULE4 - Decode access code, write, read only
// RULE5 - Reply only to valid reads
// RULE6 - Commands on supply, replies on output
// RULE7 - No access code in time: locked
// RULE8 - Controller spaces volatile writes apart
// RULE9 - Controller sends two strobes after write; the controller strobes only after non-volatile writes
// RULE10 - Device detects strobes, boosts, commits
// RULE11 - Controller limits non-volatile writes to 100; the controller keeps no count of them
// RULE12 - After read, pause sensing, send reply
// RULE13 - Resume sensing after recovery delay
// RULE14 - CRC covers data bits, not sync
// RULE15 - CRC polynomial x3 plus x plus 1
// RULE16 - CRC preset to all ones
// RULE17 - Last three frame bits hold CRC
// RULE18 - Bad CRC: ignore, no change, no reply
// RULE19 - Unlock code at 0x24 within 8 ms
// RULE20 - Permanent lock refuses all access
// RULE21 - Accept 32 to 80 kbps
// RULE22 - Measure bit period from sync pulses
// RULE23 - Reply frame uses same code and CRC
`timescale 1ns/100ps
`default_nettype none
module mlink_dev
  import mlink_pkg::*;
#(
  parameter int               UNLOCK_CYC  = UNLOCK_TIMEOUT_CYC,
  parameter logic [DATA_W-1:0] ACCESS_CODE = 30'h0a5c_3a5c  // Arbitrary value
) (
  input  wire logic                 clk_i,
  input  wire logic                 resetn_i,
  mlink_if.dev                      link,
  input  wire logic                 perm_lock_i,
  input  wire logic [REG_IDX_W-1:0] cfg_addr_i,
  output logic      [DATA_W-1:0]    cfg_data_o,
  output logic                      unlocked_o,
  output logic                      expired_o,
  output logic                      sense_pause_o,
  output logic                      nv_boost_o
);
  // One-hot link states
  typedef enum logic [6:0] {
    D_IDLE  = 7'h01,
    D_SYNC  = 7'h02,
    D_MID   = 7'h04,
    D_BITS  = 7'h08,
    D_WAIT  = 7'h10,
    D_TX    = 7'h20,
    D_RECOV = 7'h40
  } dev_st_t;

  typedef struct packed {
    dev_st_t                              st;
    logic                                 line_q;     // Last supply sample
    logic                                 hv_q;       // Last strobe sample
    logic [12:0]                          cnt;        // Cycles since event
    logic [12:0]                          tbit;       // Measured bit period
    logic [5:0]                           nbits;      // Bits after sync
    logic [40:0]                          sh;         // Received bits
    logic [2:0]                           crc;        // Running CRC
    logic [18:0]                          utmr;       // Unlock window timer
    logic                                 expired;    // Window missed
    logic                                 unlocked;   // Access code seen
    logic                                 strap_done; // Lock bit captured
    logic                                 plock;      // Permanent lock
    logic [2**REG_IDX_W-1:0][DATA_W-1:0] mem;        // Register store
    logic                                 nv_arm;     // Waiting strobes
    logic [REG_IDX_W-1:0]                 nv_idx;
    logic [DATA_W-1:0]                    nv_data;
    logic                                 strobe_one; // First strobe seen
    logic                                 boost;
    logic [34:0]                          txsh;       // Reply bits
    logic [5:0]                           txn;
    logic                                 out;
    logic                                 oe;
    logic                                 pause;
    logic [DATA_W-1:0]                    cfg;
  } dev_state_t;

  dev_state_t s_r;
  dev_state_t s_nxt;

  logic                 rise;      // Supply edges
  logic                 fall;
  logic                 is_rd;     // Frame length is a read
  logic [1:0]           f_type;
  logic [ADDR_W-1:0]    f_addr;
  logic [DATA_W-1:0]    f_data;
  logic                 frame_ok;  // CRC good and length known
  logic [12:0]          edge_min;  // Earliest mid-bit edge
  logic [12:0]          end_max;   // Silence that ends a frame

  assign rise     = link.supply_lvl & ~s_r.line_q;
  assign fall     = ~link.supply_lvl & s_r.line_q;
  assign is_rd    = (s_r.nbits == RD_BITS);
  // RULE2 MSB-first fields
  assign f_type   = is_rd ? s_r.sh[10:9] : s_r.sh[40:39];
  assign f_addr   = is_rd ? s_r.sh[8:3] : s_r.sh[38:33];
  assign f_data   = s_r.sh[32:3];
  // RULE17 CRC tail check
  assign frame_ok = (s_r.crc == 3'h0) && (is_rd || s_r.nbits == WR_BITS);
  assign edge_min = (s_r.tbit >> 1) + (s_r.tbit >> 2);
  assign end_max  = s_r.tbit + (s_r.tbit >> 1);

  // Next-state logic for the whole device end
  always_comb begin
    s_nxt        = s_r;
    s_nxt.line_q = link.supply_lvl;
    s_nxt.hv_q   = link.hv_strobe;
    s_nxt.boost  = 1'b0;
    s_nxt.cfg    = s_r.mem[cfg_addr_i];
    if (s_r.cnt != 13'h1fff) begin
      s_nxt.cnt = s_r.cnt + 13'h1;
    end
    // Lock bit is sampled once after reset release, never under reset
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.plock      = perm_lock_i;
    end
    // RULE7 unlock window timer
    if (!s_r.expired && !s_r.unlocked) begin
      if (s_r.utmr == 19'(UNLOCK_CYC - 1)) begin
        s_nxt.expired = 1'b1;
      end else begin
        s_nxt.utmr = s_r.utmr + 19'h1;
      end
    end
    // RULE10 count strobes, commit on second
    if (s_r.nv_arm && link.hv_strobe && !s_r.hv_q) begin
      if (s_r.strobe_one) begin
        s_nxt.mem[s_r.nv_idx] = s_r.nv_data;
        s_nxt.boost           = 1'b1;
        s_nxt.nv_arm          = 1'b0;
        s_nxt.strobe_one      = 1'b0;
      end else begin
        s_nxt.strobe_one = 1'b1;
      end
    end
    unique case (s_r.st)
      // RULE3 wait for controller frame start
      D_IDLE: begin
        if (fall) begin
          s_nxt.st  = D_SYNC;
          s_nxt.cnt = 13'h0;
        end
      end
      // RULE22 bit period from sync falls
      D_SYNC: begin
        if (fall) begin
          // RULE21 period within rate range
          if (s_r.cnt < BIT_MIN_CYC) begin
            s_nxt.st = D_IDLE;
          end else begin
            s_nxt.st   = D_MID;
            s_nxt.tbit = s_r.cnt;
            s_nxt.cnt  = 13'h0;
          end
        end else if (s_r.cnt > BIT_MAX_CYC) begin
          s_nxt.st = D_IDLE;
        end
      end
      // Mid edge of the second sync bit anchors data timing
      D_MID: begin
        if (rise) begin
          // RULE16 CRC preset
          s_nxt.st    = D_BITS;
          s_nxt.cnt   = 13'h0;
          s_nxt.nbits = 6'h0;
          s_nxt.crc   = CRC_PRESET;
        end else if (s_r.cnt > s_r.tbit) begin
          s_nxt.st = D_IDLE;
        end
      end
      D_BITS: begin
        // RULE1 edge direction is the bit; boundary edges fall early
        if ((rise || fall) && s_r.cnt >= edge_min) begin
          s_nxt.cnt = 13'h0;
          s_nxt.sh  = {s_r.sh[39:0], fall};
          // RULE14 RULE15 CRC over data bits
          s_nxt.crc = crc_next(s_r.crc, fall);
          if (s_r.nbits != 6'h3f) begin
            s_nxt.nbits = s_r.nbits + 6'h1;
          end
        end else if (s_r.cnt > end_max) begin
          // RULE18 bad frames just drop back
          s_nxt.st = D_IDLE;
          // RULE4 three command types decoded
          // RULE19 RULE20 code, address, window, lock
          if (frame_ok && !is_rd && f_type == CMD_ACCESS && f_addr == ACCESS_ADDR
              && f_data == ACCESS_CODE && !s_r.expired && s_r.strap_done && !s_r.plock) begin
            s_nxt.unlocked = 1'b1;
          end
          if (frame_ok && !is_rd && f_type == CMD_WRITE && s_r.unlocked) begin
            if (f_addr[NV_ADDR_BIT]) begin
              s_nxt.nv_arm     = 1'b1;
              s_nxt.strobe_one = 1'b0;
              s_nxt.nv_idx     = f_addr[REG_IDX_W-1:0];
              s_nxt.nv_data    = f_data;
            end else begin
              s_nxt.mem[f_addr[REG_IDX_W-1:0]] = f_data;
            end
          end
          // RULE5 RULE12 valid read starts reply
          if (frame_ok && is_rd && f_type == CMD_READ && s_r.unlocked) begin
            s_nxt.st    = D_WAIT;
            s_nxt.cnt   = 13'h0;
            s_nxt.pause = 1'b1;
            // RULE23 sync, data, own CRC
            s_nxt.txsh  = {SYNC_BITS[1:0] & 2'h0, s_r.mem[f_addr[REG_IDX_W-1:0]],
                           crc_calc({11'h0, s_r.mem[f_addr[REG_IDX_W-1:0]]}, DATA_BITS)};
          end
        end
      end
      // RULE12 sensing paused, reply delay
      D_WAIT: begin
        if (s_r.cnt == READ_REPLY_CYC - 13'h1) begin
          s_nxt.st  = D_TX;
          s_nxt.cnt = 13'h0;
          s_nxt.txn = 6'h0;
          s_nxt.oe  = 1'b1;
          s_nxt.out = s_r.txsh[34];
        end
      end
      // RULE6 reply on output pin
      D_TX: begin
        // RULE1 first half is the bit, second half its inverse
        s_nxt.out = (s_r.cnt < (s_r.tbit >> 1)) ? s_r.txsh[34] : ~s_r.txsh[34];
        if (s_r.cnt >= s_r.tbit - 13'h1) begin
          s_nxt.cnt  = 13'h0;
          s_nxt.txsh = {s_r.txsh[33:0], 1'b0};
          s_nxt.txn  = s_r.txn + 6'h1;
          if (s_r.txn == ACK_BITS - 6'h1) begin
            s_nxt.st = D_RECOV;
            s_nxt.oe = 1'b0;
          end
        end
      end
      // RULE13 resume sensing after two bits
      D_RECOV: begin
        if (s_r.cnt >= {s_r.tbit[11:0], 1'b0}) begin
          s_nxt.st    = D_IDLE;
          s_nxt.pause = 1'b0;
        end
      end
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_r        <= '0;
      s_r.st     <= D_IDLE;
      s_r.line_q <= 1'b1;
      s_r.hv_q   <= 1'b0;
      s_r.crc    <= CRC_PRESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.out_dev    = s_r.out;
  assign link.out_dev_oe = s_r.oe;
  assign cfg_data_o      = s_r.cfg;
  assign unlocked_o      = s_r.unlocked;
  assign expired_o       = s_r.expired;
  assign sense_pause_o   = s_r.pause;
  assign nv_boost_o      = s_r.boost;
endmodule
`default_nettype wire
